// ### design/acr_pkg.sv
/*
  Constants, register map and state type for the converter control and
  result block. Assumes an APB slave with 32-bit data and byte registers.
*/
// Overview of operation
// - Result code is input voltage times 1024 over reference; 0x3ff is full scale.
// - Two-bit reference select: external pin, analog supply, reserved, internal 1.1V.
// - Reference and channel changes wait until the running conversion completes.
// - Left adjust bit changes the result view at once, even mid-conversion.
// - Channel select: pins 0 to 7, bandgap at 11110, ground at 11111.
// - Enable bit powers converter; clearing it aborts any conversion.
// - Writing start begins a conversion; free-running needs only the first one.
// - First conversion after enabling takes 25 converter clocks, others 13.
// - Start reads one while converting; writing zero to it does nothing.
// - Auto trigger enable starts a conversion on a selected trigger rising edge seen while idle.
// - Done flag sets at conversion end; the result updates then too unless a low byte read has frozen it.
// - Interrupt request when flag, interrupt enable and global enable all set.
// - Flag clears on interrupt acknowledge or writing one; zero leaves it.
// - Prescale codes 000 and 001 divide by 2, then 4 up to 128.
// - Reading low result byte freezes the result until high byte is read.
// - Right adjust: bits 9:8 in high byte 1:0; left adjust: 9:2 high, 1:0 low 7:6.
// - Trigger select 000 is free-running; others trigger on a flag rising edge.
// - Switching from a clear source to a set one counts as a trigger edge.

package acr_pkg;

  localparam int unsigned RES_W  = 10;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PS_W   = 3;
  localparam int unsigned PS_MAX_SHIFT = 7;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_RES_LO = 8'h78;
  localparam logic [7:0] IDX_RES_HI = 8'h79;
  localparam logic [7:0] IDX_CTRL_A = 8'h7a;
  localparam logic [7:0] IDX_CTRL_B = 8'h7b;
  localparam logic [7:0] IDX_SELECT = 8'h7c;

  localparam logic [ADDR_W-1:0] ADDR_RES_LO = {2'h0, IDX_RES_LO, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = {2'h0, IDX_RES_HI, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = {2'h0, IDX_CTRL_A, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = {2'h0, IDX_CTRL_B, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SELECT = {2'h0, IDX_SELECT, 2'h0};

  // Control and status A bit positions
  localparam int unsigned CA_EN    = 7;
  localparam int unsigned CA_START = 6;
  localparam int unsigned CA_ATE   = 5;
  localparam int unsigned CA_FLAG  = 4;
  localparam int unsigned CA_IE    = 3;
  localparam int unsigned CA_PS    = 0;

  // Select register and control B field positions
  localparam int unsigned SL_REF  = 6;
  localparam int unsigned SL_LADJ = 5;
  localparam int unsigned SL_CH   = 0;
  localparam int unsigned CB_TS   = 0;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  localparam logic [2:0] TS_FREE = 3'h0;
  localparam logic [4:0] LEN_FIRST  = 5'h19;
  localparam logic [4:0] LEN_NORMAL = 5'h0d;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_WAIT = 2'b01,
    ACR_CONV = 2'b10
  } acr_state_t;

endpackage

// ### design/acr_prescaler.sv
/*
  Converter clock prescaler: one-cycle tick every 2 to 128 system clocks.
  Assumes the select code comes from a register on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module acr_prescaler
  import acr_pkg::*;
#(
  parameter int unsigned DIV_W = 7
)(
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            run_i,
  input  wire logic [PS_W-1:0] sel_i,
  output logic                 tick_o
);

  if (DIV_W < PS_MAX_SHIFT) begin : g_chk
    $error("acr_prescaler: DIV_W too small for divide by 128");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] last;

  // Codes 0 and 1 both divide by two
  function automatic logic [DIV_W-1:0] last_count(input logic [PS_W-1:0] s);
    logic [DIV_W:0] full;
    full = {{DIV_W{1'b0}}, 1'b1} << ((s == '0) ? 1 : s);
    last_count = full[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
  endfunction

  assign last = last_count(sel_i);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### design/acr_adc_ctrl.sv
/*
  Converter control, status and result registers behind an APB slave.
  Assumes an analog core that holds a stable 10-bit code when a conversion
  ends, trigger flags from logic on the same clock, and a CPU that gives
  the global interrupt enable and the interrupt acknowledge pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module acr_adc_ctrl
  import acr_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic [RES_W-1:0]  conv_data_i,
  input  wire logic [7:0]        trigger_i,
  input  wire logic              global_irq_enable_i,
  input  wire logic              irq_ack_i,
  output logic                   converter_power_o,
  output logic [1:0]             reference_select_o,
  output logic                   internal_ref_on_o,
  output logic [4:0]             channel_select_o,
  output logic                   sample_start_o,
  output logic                   converter_tick_o,
  output logic                   irq_o
);

  acr_state_t       state_q;
  logic             en_q;
  logic             ate_q;
  logic             flag_q;
  logic             ie_q;
  logic [PS_W-1:0]  ps_q;
  logic [1:0]       ref_q;
  logic             ladj_q;
  logic [4:0]       ch_q;
  logic [2:0]       ts_q;
  logic             init_q;
  logic [4:0]       len_q;
  logic [4:0]       cnt_q;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] data_meta_q;
  logic [RES_W-1:0] data_sync_q;
  logic             lock_q;
  logic             trig_prev_q;

  logic             setup;
  logic             access;
  logic             wr_acc;
  logic [7:0]       wb;
  logic             wr_ca;
  logic             tick;
  logic             abort;
  logic             start_req;
  logic             trig_now;
  logic             trig_start;
  logic             done;
  logic             free_run;
  logic [15:0]      view;

  // Left or right justified view of the 10-bit result
  function automatic logic [15:0] result_view(input logic [RES_W-1:0] r,
                                              input logic l);
    result_view = l ? {r, 6'h00} : {6'h00, r};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == ADDR_RES_LO) || (a == ADDR_RES_HI) || (a == ADDR_CTRL_A) ||
             (a == ADDR_CTRL_B) || (a == ADDR_SELECT);
  endfunction

  // Bus decode
  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_o;
  assign wr_acc = access & pwrite_i;
  assign wb     = pwdata_i[7:0];
  assign wr_ca  = wr_acc & (paddr_i == ADDR_CTRL_A);

  // Conversion control terms
  assign abort      = wr_ca & ~wb[CA_EN];
  assign start_req  = wr_ca & wb[CA_START] & wb[CA_EN];
  assign free_run   = ate_q & (ts_q == TS_FREE);
  assign trig_now   = (ts_q == TS_FREE) ? 1'b0 : trigger_i[ts_q];
  assign trig_start = en_q & ate_q & trig_now & ~trig_prev_q;
  assign done       = (state_q == ACR_CONV) & tick & (cnt_q == len_q - 5'h01);
  assign view       = result_view(result_q, ladj_q);
  assign tick       = converter_tick_o;

  acr_prescaler #(
    .DIV_W (PS_MAX_SHIFT)
  ) u_prescaler (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (en_q),
    .sel_i     (ps_q),
    .tick_o    (converter_tick_o)
  );

  // APB answer: ready in the first access cycle, data fixed at setup
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped(paddr_i);
      if (setup & ~pwrite_i) begin
        unique case (paddr_i)
          ADDR_RES_LO: prdata_o <= {24'h000000, view[7:0]};
          ADDR_RES_HI: prdata_o <= {24'h000000, view[15:8]};
          ADDR_CTRL_A: prdata_o <= {24'h000000, en_q, state_q != ACR_IDLE,
                                    ate_q, flag_q, ie_q, ps_q};
          ADDR_CTRL_B: prdata_o <= {29'h00000000, ts_q};
          ADDR_SELECT: prdata_o <= {24'h000000, ref_q, ladj_q, ch_q};
          default:     prdata_o <= '0;
        endcase
      end
    end
  end

  // Control fields; start is not stored, it is the busy state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q  <= BYTE_RESET[CA_EN];
      ate_q <= BYTE_RESET[CA_ATE];
      ie_q  <= BYTE_RESET[CA_IE];
      ps_q  <= BYTE_RESET[CA_PS +: PS_W];
    end else if (wr_ca) begin
      en_q  <= wb[CA_EN];
      ate_q <= wb[CA_ATE];
      ie_q  <= wb[CA_IE];
      ps_q  <= wb[CA_PS +: PS_W];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_q  <= BYTE_RESET[SL_REF +: 2];
      ladj_q <= BYTE_RESET[SL_LADJ];
      ch_q   <= BYTE_RESET[SL_CH +: 5];
    end else if (wr_acc & (paddr_i == ADDR_SELECT)) begin
      ref_q  <= wb[SL_REF +: 2];
      ladj_q <= wb[SL_LADJ];
      ch_q   <= wb[SL_CH +: 5];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ts_q <= BYTE_RESET[CB_TS +: 3];
    end else if (wr_acc & (paddr_i == ADDR_CTRL_B)) begin
      ts_q <= wb[CB_TS +: 3];
    end
  end

  // Trigger edge history follows the selected source, so a switch counts
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_now;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ACR_IDLE;
    end else if (abort) begin
      state_q <= ACR_IDLE;
    end else begin
      unique case (state_q)
        ACR_IDLE: begin
          if (start_req | trig_start) begin
            state_q <= ACR_WAIT;
          end
        end
        ACR_WAIT: begin
          if (tick) begin
            state_q <= ACR_CONV;
          end
        end
        ACR_CONV: begin
          if (done) begin
            state_q <= free_run ? ACR_WAIT : ACR_IDLE;
          end
        end
        default: begin
          state_q <= ACR_IDLE;
        end
      endcase
    end
  end

  // Length chosen when a conversion is requested
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_q <= 1'b0;
      len_q  <= LEN_FIRST;
    end else if (abort) begin
      init_q <= 1'b0;
    end else if ((state_q == ACR_IDLE) & (start_req | trig_start)) begin
      init_q <= 1'b1;
      len_q  <= init_q ? LEN_NORMAL : LEN_FIRST;
    end else if (done) begin
      len_q  <= LEN_NORMAL;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (state_q != ACR_CONV) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_start_o <= 1'b0;
    end else begin
      sample_start_o <= (state_q == ACR_WAIT) & tick & ~abort;
    end
  end

  // Applied selections only move while no conversion is running
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reference_select_o <= '0;
      internal_ref_on_o  <= 1'b0;
      channel_select_o   <= '0;
      converter_power_o  <= 1'b0;
    end else begin
      converter_power_o <= en_q;
      if ((state_q == ACR_IDLE) | done) begin
        reference_select_o <= ref_q;
        internal_ref_on_o  <= (ref_q == REF_INTERNAL);
        channel_select_o   <= ch_q;
      end
    end
  end

  // Core holds its code steady at the end, so a plain two-stage bus is enough
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_meta_q <= '0;
      data_sync_q <= '0;
    end else begin
      data_meta_q <= conv_data_i;
      data_sync_q <= data_meta_q;
    end
  end

  // Result capture, frozen between low and high byte reads
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_q <= '0;
    end else if (done & ~lock_q) begin
      result_q <= data_sync_q;
    end
  end

  // Lock taken at the low read setup, so both bytes come from one result unless a conversion ends in that same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_q <= 1'b0;
    end else if (access & ~pwrite_i & (paddr_i == ADDR_RES_HI)) begin
      lock_q <= 1'b0;
    end else if (setup & ~pwrite_i & (paddr_i == ADDR_RES_LO)) begin
      lock_q <= 1'b1;
    end
  end

  // Completion flag: a completion in the clearing cycle still sets it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1;
    end else if (irq_ack_i | (wr_ca & wb[CA_FLAG])) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag_q & ie_q & global_irq_enable_i;
    end
  end

endmodule

`default_nettype wire

// ### tb/acr_analog_model.sv
/*
  Behavioural analog sample-and-convert core for the converter block.
  Assumes the controller's applied selections and its sample pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module acr_analog_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic       power_i,
  input  wire logic [1:0] ref_i,
  input  wire logic [4:0] ch_i,
  output logic      [9:0] code_o
);
  logic [9:0] held_q = 10'h2aa;

  // Code fixed at sampling so it is steady long before the end
  always_ff @(posedge clk_i) begin
    if (start_i) begin
      held_q <= {ref_i, 3'h5, ch_i};
    end
  end

  // Unpowered core gives no valid code
  assign code_o = power_i ? held_q : ~held_q;
endmodule

`default_nettype wire

// ### tb/acr_adc_ctrl_asserts.sv
/*
  Port checker for the converter control block.
  Assumes binding to acr_adc_ctrl on its single clock.
*/
`timescale 1ns/10ps
`default_nettype none

module acr_adc_ctrl_asserts (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       global_irq_enable_i,
  input wire logic       irq_o,
  input wire logic       converter_power_o,
  input wire logic       converter_tick_o,
  input wire logic       sample_start_o,
  input wire logic [1:0] reference_select_o,
  input wire logic       internal_ref_on_o,
  input wire logic [4:0] channel_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_pready_one: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access cycle");
  a_pready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_slverr_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_irq_global: assert property (irq_o |-> $past(global_irq_enable_i))
    else $error("irq without global enable");
  a_ref_internal: assert property (internal_ref_on_o == (reference_select_o == 2'h3))
    else $error("internal reference mismatch");
  a_sel_frozen: assert property (sample_start_o |=>
    ($stable(channel_select_o) && $stable(reference_select_o))[*8])
    else $error("selection moved in conversion");
  a_start_gap: assert property (sample_start_o |=> !sample_start_o[*8])
    else $error("conversions too close");
  a_tick_gap: assert property (converter_tick_o |=> !converter_tick_o)
    else $error("converter clock faster than half");
  a_tick_power: assert property (converter_tick_o |-> converter_power_o)
    else $error("tick while powered off");
endmodule

bind acr_adc_ctrl acr_adc_ctrl_asserts acr_adc_ctrl_asserts_i (
  .clk_i, .reset_n_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .global_irq_enable_i, .irq_o, .converter_power_o, .converter_tick_o,
  .sample_start_o, .reference_select_o, .internal_ref_on_o, .channel_select_o);

`default_nettype wire

// ### tb/acr_adc_ctrl_tb.sv
/*
  Self-checking bench for the converter control block over APB.
  Assumes the analog model and the bound port checker.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module acr_adc_ctrl_tb;
  import acr_pkg::*;
  logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic global_irq_enable_i = 1, irq_ack_i = 0, err, irq_q = 0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [DATA_W-1:0] pwdata_i = '0, prdata_o, rd;
  logic [9:0] conv_data_i;
  logic [7:0] trigger_i = 8'h00;
  logic [1:0] reference_select_o;
  logic [4:0] channel_select_o;
  logic pready_o, pslverr_o, converter_power_o, internal_ref_on_o;
  logic sample_start_o, converter_tick_o, irq_o;
  int error_cnt = 0, n_tests = 0, cyc = 0, nt = 0, td = 0, gap = 0, cnt = 0;

  acr_adc_ctrl acr_adc_ctrl_i (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .conv_data_i, .trigger_i,
    .global_irq_enable_i, .irq_ack_i, .converter_power_o, .reference_select_o,
    .internal_ref_on_o, .channel_select_o, .sample_start_o, .converter_tick_o, .irq_o);
  acr_analog_model acr_analog_model_i (.clk_i, .start_i(sample_start_o),
    .power_i(converter_power_o), .ref_i(reference_select_o), .ch_i(channel_select_o),
    .code_o(conv_data_i));

  always #10 clk_i = ~clk_i;

  // Tick count per conversion and tick spacing, for timing checks
  always @(posedge clk_i) begin
    cyc++;
    irq_q <= irq_o;
    if (sample_start_o) nt <= 0;
    else if (converter_tick_o) nt <= nt + 1;
    if (irq_o && !irq_q) td <= nt;
    if (converter_tick_o) begin gap <= cnt; cnt <= 1; end
    else cnt <= cnt + 1;
    if (cyc == 60000) begin error_cnt++; summarize(); end
  end

  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Master holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w;
    paddr_i <= {2'h0, idx, 2'h0}; pwdata_i <= {24'h0, wd};
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (!pready_o);
    rd = prdata_o; err = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(0, idx, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask

  // Bounded wait: 0 irq, 1 sample start, 2 tick
  task automatic wait_for(input int k);
    int i;
    for (i = 0; i < 9000; i++) begin
      @(posedge clk_i);
      if (k == 0 ? irq_o : k == 1 ? sample_start_o : converter_tick_o) return;
    end
    `CHK(1'b0, 1'b1)
  endtask

  task automatic t_regs();
    rdchk(IDX_CTRL_A, 8'h00);
    rdchk(IDX_RES_LO, 8'h00);
    rdchk(IDX_RES_HI, 8'h00);
    rdchk(IDX_SELECT, 8'h00);
    rdchk(8'h10, 8'h00);
    `CHK(err, 1'b1)
    $display("regs done");
  endtask

  task automatic t_prescale();
    for (int c = 0; c < 8; c++) begin
      apb(1, IDX_CTRL_A, 8'h80 | c[7:0]);
      repeat (3) wait_for(2);
      @(negedge clk_i);
      `CHK(gap, (c < 2) ? 2 : (1 << c))
    end
    apb(1, IDX_CTRL_A, 8'h00);
    $display("prescale done");
  endtask

  task automatic t_single();
    apb(1, IDX_SELECT, 8'h43);
    apb(1, IDX_CTRL_A, 8'hca);
    rdchk(IDX_CTRL_A, 8'hca);
    apb(1, IDX_CTRL_A, 8'h8a);
    rdchk(IDX_CTRL_A, 8'hca);
    wait_for(0);
    @(negedge clk_i);
    `CHK(td, 25)
    rdchk(IDX_CTRL_A, 8'h9a);
    rdchk(IDX_RES_LO, 8'ha3);
    rdchk(IDX_RES_HI, 8'h01);
    apb(1, IDX_SELECT, 8'h63);
    rdchk(IDX_RES_HI, 8'h68);
    rdchk(IDX_RES_LO, 8'hc0);
    $display("single done");
  endtask

  task automatic t_second();
    @(posedge clk_i) irq_ack_i <= 1;
    @(posedge clk_i) irq_ack_i <= 0;
    rdchk(IDX_CTRL_A, 8'h8a);
    apb(1, IDX_SELECT, 8'h05);
    rdchk(IDX_RES_LO, 8'ha3);
    apb(1, IDX_CTRL_A, 8'hca);
    wait_for(1);
    apb(1, IDX_SELECT, 8'hdf);
    `CHK(channel_select_o, 5'h05)
    `CHK(reference_select_o, 2'h0)
    wait_for(0);
    @(negedge clk_i);
    `CHK(td, 13)
    `CHK(channel_select_o, 5'h1f)
    `CHK(reference_select_o, 2'h3)
    `CHK(internal_ref_on_o, 1'b1)
    rdchk(IDX_RES_HI, 8'h01);
    rdchk(IDX_RES_LO, 8'ha3);
    apb(1, IDX_CTRL_A, 8'h9a);
    rdchk(IDX_CTRL_A, 8'h8a);
    `CHK(irq_o, 1'b0)
    $display("second done");
  endtask

  task automatic t_abort();
    apb(1, IDX_CTRL_A, 8'hca);
    wait_for(1);
    apb(1, IDX_CTRL_A, 8'h00);
    rdchk(IDX_CTRL_A, 8'h00);
    repeat (150) @(posedge clk_i);
    `CHK(converter_power_o, 1'b0)
    `CHK(irq_o, 1'b0)
    $display("abort done");
  endtask

  task automatic t_trigger();
    apb(1, IDX_CTRL_B, 8'h01);
    apb(1, IDX_CTRL_A, 8'haa);
    @(posedge clk_i) trigger_i <= 8'h02;
    wait_for(0);
    @(negedge clk_i);
    `CHK(td, 25)
    apb(1, IDX_CTRL_B, 8'h00);
    apb(1, IDX_CTRL_A, 8'hba);
    repeat (100) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    apb(1, IDX_CTRL_A, 8'hfa);
    repeat (3) wait_for(1);
    rdchk(IDX_CTRL_A, 8'hfa);
    apb(1, IDX_CTRL_A, 8'h00);
    $display("trigger done");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1;
    t_regs();
    t_prescale();
    t_single();
    t_second();
    t_abort();
    t_trigger();
    summarize();
  end
endmodule

`default_nettype wire
